// file: shared_memory_mailbox_link.sv
// Minicomputer-side mailbox engine over shared memory
//
// Notes on behaviour
// R1 - FIFO is empty when get and put pointers are equal.
// R2 - FIFO is full when put is one behind get; no byte is added then.
// R3 - Each async mailbox holds a capacity word, one less than storage words.
// R4 - FIFO storage is 16-bit words, one byte in the low 8 bits.
// R5 - Pointers are word offsets ranging from zero to the capacity word.
// R6 - Byte count is put minus get, corrected for wraparound.
// R7 - Only the inserter moves put; only the remover moves get.
// R8 - PC queues to the minicomputer, interrupting only if queue was empty.
// R9 - Sending: fill mailbox, append address, set attention flag, interrupt PC.
// R10 - Non-async mailboxes interrupt the PC right after queuing.
// R11 - Timer-eligible async mailboxes start a timer; interrupt only on expiry.
// R12 - PC checks attention flag, reads queue, clears flag, runs service.
// R13 - PC handler drains the inbound queue until it is empty.
// R14 - PC enables transmit interrupt, drains mailbox, disables when empty.
// R15 - PC keeps every serial receive interrupt enabled.
// R16 - PC interrupts minicomputer only when the mailbox was empty before.
// R17 - Disk mailbox has high and low address words and a word count.
// R18 - Enough 1kword pages are reserved for the disk word count.
// R19 - Queue pointers sit at fixed offsets 8030h and 8032h.
// R20 - Each address queue has the async mailbox structure with pointers.
// R21 - Console and status traffic use a 4-word reserved area.
// R22 - Printer ownership is exclusive; the other side waits for release.
// R23 - A pointer past the capacity value wraps back to zero.
`timescale 1ns/1ps
module shared_memory_mailbox_link import mailbox_link_pkg::*; (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        pc_sel_i,
  input  wire logic        pc_wr_i,
  input  wire logic [15:0] pc_addr_i,
  input  wire logic [15:0] pc_wdata_i,
  output logic [15:0]      pc_rdata_o,
  input  wire logic        cmd_valid_i,
  input  wire cmd_type     cmd_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output rsp_type          rsp_o,
  output logic             attention_flag_o,
  output logic             irq_pc_o,
  output logic [23:0]      disk_addr_o,
  output logic [6:0]       disk_pages_o,
  input  wire logic        printer_req_i,
  output owner_type        printer_owner_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_ADV, ST_FLAG, ST_NOTIFY, ST_RESP
  } state_type;

  state_type            state_q;
  cmd_type              cmd_q;
  rsp_type              rsp_q;
  logic [7:0]           base_q;
  logic [15:0]          mem_q [MEM_WORDS];
  logic [15:0]          pc_to_host_q;
  logic [15:0]          host_to_pc_q;
  logic                 attention_q;
  logic                 pc_print_req_q;
  owner_type            owner_q;
  logic                 timer_run_q;
  logic [TIMER_W-1:0]   timer_cnt_q;
  logic                 irq_q;
  logic [15:0]          pc_rdata_q;
  logic [23:0]          disk_addr_q;
  logic [6:0]           disk_pages_q;
  logic                 pc_in_win;
  logic                 pc_reg_hit;
  logic [7:0]           pc_idx;
  logic                 dev_wr;
  logic [7:0]           dev_idx;
  logic [15:0]          dev_wdata;
  logic [7:0]           cap_w;
  logic [7:0]           get_w;
  logic [7:0]           put_w;
  logic                 empty_w;
  logic                 full_w;
  logic [7:0]           count_w;
  logic [7:0]           put_next_w;
  logic [7:0]           get_next_w;
  logic                 timed_w;
  logic [16:0]          wcnt_round_w;

  // ----------------------------------------------------------------
  // Shared-memory port from the PC
  // ----------------------------------------------------------------
  assign pc_in_win  = pc_sel_i && (pc_addr_i[15:9] == WIN_BASE[15:9]);
  assign pc_idx     = pc_addr_i[8:1];
  assign pc_reg_hit = (pc_addr_i == OFS_PC_TO_HOST_Q) ||
                      (pc_addr_i == OFS_HOST_TO_PC_Q) ||
                      (pc_addr_i == OFS_ATTENTION) ||
                      (pc_addr_i == OFS_PRINTER);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pc_to_host_q <= RST_Q_PTR;
      host_to_pc_q <= RST_Q_PTR;
    end else if (pc_sel_i && pc_wr_i) begin
      if (pc_addr_i == OFS_PC_TO_HOST_Q) begin
        pc_to_host_q <= pc_wdata_i; // R19
      end
      if (pc_addr_i == OFS_HOST_TO_PC_Q) begin
        host_to_pc_q <= pc_wdata_i; // R19
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pc_rdata_q <= 16'h0000;
    end else if (pc_sel_i && !pc_wr_i) begin
      if (pc_addr_i == OFS_PC_TO_HOST_Q) begin
        pc_rdata_q <= pc_to_host_q;
      end else if (pc_addr_i == OFS_HOST_TO_PC_Q) begin
        pc_rdata_q <= host_to_pc_q;
      end else if (pc_addr_i == OFS_ATTENTION) begin
        pc_rdata_q <= {15'h0000, attention_q};
      end else if (pc_addr_i == OFS_PRINTER) begin
        pc_rdata_q <= {13'h0000, owner_q, pc_print_req_q};
      end else if (pc_in_win) begin
        pc_rdata_q <= mem_q[pc_idx];
      end else begin
        pc_rdata_q <= 16'h0000;
      end
    end
  end

  // Console area is plain memory at CONSOLE_IDX, open to both sides
  always_ff @(posedge ref_clk_i) begin
    if (pc_in_win && pc_wr_i && !pc_reg_hit) begin
      mem_q[pc_idx] <= pc_wdata_i; // R21
    end
    if (dev_wr) begin
      mem_q[dev_idx] <= dev_wdata;
    end
  end

  // ----------------------------------------------------------------
  // FIFO header of the mailbox being worked on
  // ----------------------------------------------------------------
  assign cap_w = mem_q[8'(base_q + HDR_CAP)][7:0]; // R3
  assign get_w = mem_q[8'(base_q + HDR_GET)][7:0]; // R5
  assign put_w = mem_q[8'(base_q + HDR_PUT)][7:0]; // R5

  fifo_ptr_calc u_calc (
    .cap_i      (cap_w),
    .get_i      (get_w),
    .put_i      (put_w),
    .empty_o    (empty_w),
    .full_o     (full_w),
    .count_o    (count_w),
    .put_next_o (put_next_w),
    .get_next_o (get_next_w)
  );

  assign timed_w = cmd_q.async_box && cmd_q.timer_ok;

  // Only put is written when adding and only get when removing
  always_comb begin
    dev_wr    = 1'b0;
    dev_idx   = 8'h00;
    dev_wdata = 16'h0000;
    if (state_q == ST_CHECK) begin
      if ((cmd_q.op == OP_SEND || cmd_q.op == OP_PUT_BYTE) && !full_w) begin
        dev_wr    = 1'b1;
        dev_idx   = 8'(base_q + HDR_DATA + put_w);
        dev_wdata = {8'h00, cmd_q.data[7:0]}; // R4
      end else if (cmd_q.op == OP_MEM_WR) begin
        dev_wr    = 1'b1;
        dev_idx   = base_q;
        dev_wdata = cmd_q.data;
      end
    end else if (state_q == ST_ADV) begin
      dev_wr = 1'b1;
      if (cmd_q.op == OP_GET) begin
        dev_idx   = 8'(base_q + HDR_GET);
        dev_wdata = {8'h00, get_next_w}; // R7
      end else begin
        dev_idx   = 8'(base_q + HDR_PUT);
        dev_wdata = {8'h00, put_next_w}; // R7
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cmd_q   <= '0;
      base_q  <= 8'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cmd_valid_i) begin
            cmd_q   <= cmd_i;
            state_q <= ST_CHECK;
            if (cmd_i.op == OP_SEND) begin
              base_q <= host_to_pc_q[7:0]; // R20
            end else if (cmd_i.op == OP_GET) begin
              base_q <= pc_to_host_q[7:0]; // R20
            end else begin
              base_q <= cmd_i.addr;
            end
          end
        end
        ST_CHECK: begin
          if ((cmd_q.op == OP_SEND || cmd_q.op == OP_PUT_BYTE) && !full_w) begin
            state_q <= ST_ADV; // R2
          end else if (cmd_q.op == OP_GET && !empty_w) begin
            state_q <= ST_ADV; // R1
          end else begin
            state_q <= ST_RESP;
          end
        end
        ST_ADV: begin
          state_q <= (cmd_q.op == OP_SEND) ? ST_FLAG : ST_RESP; // R9
        end
        ST_FLAG:   state_q <= ST_NOTIFY; // R9
        ST_NOTIFY: state_q <= ST_RESP;
        ST_RESP:   state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rsp_q <= '0;
    end else if (state_q == ST_CHECK) begin
      unique case (cmd_q.op)
        OP_SEND, OP_PUT_BYTE: begin
          rsp_q.ok   <= !full_w; // R2
          rsp_q.data <= {8'h00, count_w}; // R6
        end
        OP_GET: begin
          rsp_q.ok   <= !empty_w; // R1
          rsp_q.data <= empty_w ? 16'h0000 :
                        {8'h00, mem_q[8'(base_q + HDR_DATA + get_w)][7:0]};
        end
        OP_MEM_RD: begin
          rsp_q.ok   <= 1'b1;
          rsp_q.data <= mem_q[base_q];
        end
        default: begin
          rsp_q.ok   <= 1'b1;
          rsp_q.data <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Disk mailbox decode
  // ----------------------------------------------------------------
  assign wcnt_round_w = {1'b0, mem_q[8'(base_q + DSK_WCNT)]} +
                        17'(PAGE_WORDS - 1);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      disk_addr_q  <= 24'h000000;
      disk_pages_q <= 7'h00;
    end else if (state_q == ST_CHECK && cmd_q.op == OP_DISK) begin
      disk_addr_q  <= {mem_q[8'(base_q + DSK_ADDR_HI)][7:0],
                       mem_q[8'(base_q + DSK_ADDR_LO)]}; // R17
      disk_pages_q <= 7'(wcnt_round_w >> PAGE_SHIFT); // R18
    end
  end

  // ----------------------------------------------------------------
  // Attention flag, interrupt and delay timer
  // ----------------------------------------------------------------
  // A set in the same cycle as the PC clearing it is kept
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      attention_q <= 1'b0;
    end else if (state_q == ST_FLAG) begin
      attention_q <= 1'b1; // R9
    end else if (pc_sel_i && pc_wr_i && pc_addr_i == OFS_ATTENTION &&
                 !pc_wdata_i[0]) begin
      attention_q <= 1'b0;
    end
  end

  // One timer only; a later timed send rides on the running delay
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      timer_run_q <= 1'b0;
      timer_cnt_q <= '0;
    end else if (timer_run_q) begin
      timer_cnt_q <= TIMER_W'(timer_cnt_q - 1'b1);
      if (timer_cnt_q == TIMER_W'(1)) begin
        timer_run_q <= 1'b0;
      end
    end else if (state_q == ST_NOTIFY && timed_w) begin
      timer_run_q <= 1'b1; // R11
      timer_cnt_q <= TIMER_W'(IRQ_DELAY_CYC);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (state_q == ST_NOTIFY && !timed_w) || // R10
               (timer_run_q && timer_cnt_q == TIMER_W'(1)); // R11
    end
  end

  // ----------------------------------------------------------------
  // Printer ownership
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pc_print_req_q <= 1'b0;
    end else if (pc_sel_i && pc_wr_i && pc_addr_i == OFS_PRINTER) begin
      pc_print_req_q <= pc_wdata_i[0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      owner_q <= OWN_NONE;
    end else begin
      unique case (owner_q)
        OWN_NONE: begin
          if (printer_req_i) begin
            owner_q <= OWN_HOST;
          end else if (pc_print_req_q) begin
            owner_q <= OWN_PC;
          end
        end
        OWN_HOST: if (!printer_req_i) owner_q <= OWN_NONE; // R22
        OWN_PC:   if (!pc_print_req_q) owner_q <= OWN_NONE; // R22
        default:  owner_q <= OWN_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pc_rdata_o       = pc_rdata_q;
  assign cmd_ready_o      = (state_q == ST_IDLE);
  assign rsp_valid_o      = (state_q == ST_RESP);
  assign rsp_o            = rsp_q;
  assign attention_flag_o = attention_q;
  assign irq_pc_o         = irq_q;
  assign disk_addr_o      = disk_addr_q;
  assign disk_pages_o     = disk_pages_q;
  assign printer_owner_o  = owner_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence append_s;
    state_q == ST_ADV && cmd_q.op == OP_SEND;
  endsequence
  sequence flag_then_notify_s;
    state_q == ST_FLAG ##1 (attention_q && state_q == ST_NOTIFY);
  endsequence

  AST_SEND_ORDER: assert property (append_s |=> flag_then_notify_s) // R9
    else $error("send did not set attention before notifying");
  AST_EMPTY_REFUSE: assert property ( // R1
    state_q == ST_CHECK && cmd_q.op == OP_GET && get_w == put_w
    |=> rsp_valid_o && !rsp_o.ok)
    else $error("get from empty fifo was not refused");
  AST_FULL_REFUSE: assert property ( // R2
    state_q == ST_CHECK && cmd_q.op == OP_PUT_BYTE && full_w
    |-> !dev_wr ##1 (rsp_valid_o && !rsp_o.ok))
    else $error("byte added to full fifo");
  AST_PUT_WRAP: assert property ( // R23
    state_q == ST_ADV && cmd_q.op != OP_GET && put_w == cap_w
    |=> mem_q[8'($past(base_q) + HDR_PUT)] == 16'h0000)
    else $error("put pointer did not wrap to zero");
  AST_DIRECT_IRQ: assert property ( // R10
    state_q == ST_NOTIFY && !timed_w |=> irq_pc_o)
    else $error("untimed mailbox did not interrupt at once");
  AST_TIMER_HOLD: assert property ( // R11
    $rose(timer_run_q) |-> !irq_pc_o [*8])
    else $error("interrupt raised while delay timer runs");
  AST_TIMER_FIRE: assert property ( // R11
    timer_run_q && timer_cnt_q == TIMER_W'(1) |=> irq_pc_o && !timer_run_q)
    else $error("timer expiry did not interrupt");
  AST_DISK_ADDR: assert property ( // R17
    state_q == ST_CHECK && cmd_q.op == OP_DISK
    |=> disk_addr_o[15:0] == $past(mem_q[8'(base_q + DSK_ADDR_LO)]))
    else $error("disk address low word wrong");
  AST_PRINTER_EXCL: assert property ( // R22
    owner_q == OWN_HOST |=> owner_q != OWN_PC)
    else $error("printer handed over without release");

endmodule

// file: mailbox_link_pkg.sv
// Shared constants and types of the shared-memory mailbox link
package mailbox_link_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int IRQ_DELAY_NS  = 50000;
  localparam int IRQ_DELAY_CYC = (IRQ_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 IRQ_DELAY_NS / CLK_PERIOD_NS;
  localparam int TIMER_W       = 12;

  // ----------------------------------------------------------------
  // Shared-memory window and fixed locations (PC byte offsets)
  // ----------------------------------------------------------------
  localparam int          MEM_WORDS        = 256;
  localparam logic [15:0] WIN_BASE         = 16'h8000;
  localparam logic [15:0] OFS_PC_TO_HOST_Q = 16'h8030;
  localparam logic [15:0] OFS_HOST_TO_PC_Q = 16'h8032;
  localparam logic [15:0] OFS_ATTENTION    = 16'h8034;
  localparam logic [15:0] OFS_PRINTER      = 16'h8036;
  localparam logic [7:0]  CONSOLE_IDX      = 8'h1C;
  localparam int          CONSOLE_WORDS    = 4;
  localparam logic [15:0] RST_Q_PTR        = 16'h0000;

  // ----------------------------------------------------------------
  // Mailbox field layouts (word offsets from the mailbox base)
  // ----------------------------------------------------------------
  localparam logic [7:0] HDR_CAP     = 8'h00;
  localparam logic [7:0] HDR_GET     = 8'h01;
  localparam logic [7:0] HDR_PUT     = 8'h02;
  localparam logic [7:0] HDR_DATA    = 8'h03;
  localparam logic [7:0] DSK_ADDR_HI = 8'h00;
  localparam logic [7:0] DSK_ADDR_LO = 8'h01;
  localparam logic [7:0] DSK_WCNT    = 8'h02;
  localparam int         PAGE_WORDS  = 1024;
  localparam int         PAGE_SHIFT  = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_SEND, OP_PUT_BYTE, OP_GET, OP_MEM_WR, OP_MEM_RD, OP_DISK
  } op_type;

  typedef struct packed {
    op_type      op;
    logic [7:0]  addr;
    logic [15:0] data;
    logic        async_box;
    logic        timer_ok;
  } cmd_type;

  typedef struct packed {
    logic [15:0] data;
    logic        ok;
  } rsp_type;

  typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_PC} owner_type;

endpackage

// file: fifo_ptr_calc.sv
// Pointer arithmetic of one circular byte FIFO
`timescale 1ns/1ps
module fifo_ptr_calc import mailbox_link_pkg::*; (
  input  wire logic [7:0] cap_i,
  input  wire logic [7:0] get_i,
  input  wire logic [7:0] put_i,
  output logic            empty_o,
  output logic            full_o,
  output logic [7:0]      count_o,
  output logic [7:0]      put_next_o,
  output logic [7:0]      get_next_o
);

  assign put_next_o = (put_i == cap_i) ? 8'h00 : 8'(put_i + 8'h01); // R23
  assign get_next_o = (get_i == cap_i) ? 8'h00 : 8'(get_i + 8'h01); // R23
  assign empty_o    = (put_i == get_i);                             // R1
  // One word stays unused so full and empty never look alike
  assign full_o     = (put_next_o == get_i);                        // R2
  assign count_o    = (put_i >= get_i) ? 8'(put_i - get_i) :
                      8'(put_i + cap_i + 8'h01 - get_i);            // R6

endmodule

// file: pc_side_model.sv
// Behavioural model of the PC processor on the shared-memory bus
`timescale 1ns/1ps
module pc_side_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic             sel_o,
  output logic             wr_o,
  output logic [15:0]      addr_o,
  output logic [15:0]      wdata_o
);
  logic [7:0] boxes[$];
  initial begin
    sel_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  // Released address and data lines show the inverted value, never the last one; wr_o keeps its value
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_i);
    sel_o <= 1'b1;
    wr_o <= w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    sel_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
    #1 q = rdata_i;
  endtask
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    logic [15:0] q;
    acc(1'b1, {7'h40, i, 1'b0}, d, q);
  endtask
  task automatic rd(input logic [7:0] i, output logic [15:0] q);
    acc(1'b0, {7'h40, i, 1'b0}, 16'h0000, q);
  endtask
  task automatic service();
    logic [15:0] f, b, g, p, c, w;
    acc(1'b0, 16'h8034, 16'h0000, f);
    if (f[0] !== 1'b1) return;
    acc(1'b0, 16'h8032, 16'h0000, b);
    rd(b[7:0], c);
    rd(b[7:0] + 8'h01, g);
    rd(b[7:0] + 8'h02, p);
    acc(1'b1, 16'h8034, 16'h0000, w);
    while (g !== p) begin
      rd(b[7:0] + 8'h03 + g[7:0], w);
      boxes.push_back(w[7:0]);
      g = (g == c) ? 16'h0000 : g + 16'h0001;
      wr(b[7:0] + 8'h01, g);
    end
  endtask
  // Data word lands before the pointer, so no half-written byte is seen
  task automatic put(input logic [7:0] v);
    logic [15:0] b, c, g, p, n;
    acc(1'b0, 16'h8030, 16'h0000, b);
    rd(b[7:0], c);
    rd(b[7:0] + 8'h01, g);
    rd(b[7:0] + 8'h02, p);
    n = (p == c) ? 16'h0000 : p + 16'h0001;
    if (n == g) return;
    wr(b[7:0] + 8'h03 + p[7:0], {8'h00, v});
    wr(b[7:0] + 8'h02, n);
  endtask
endmodule

// file: shared_memory_mailbox_link_tb.sv
// Self-checking testbench of the shared-memory mailbox link
`timescale 1ns/1ps
module shared_memory_mailbox_link_tb import mailbox_link_pkg::*;;
  typedef struct packed {logic chk; rsp_type r;} exp_type;
  logic clk, rst, cmd_valid, preq, sel, wr, attn, irq, ready, rvalid;
  logic [15:0] addr, wdata, rdata;
  logic [23:0] daddr;
  logic [6:0] dpages;
  cmd_type cmd;
  rsp_type rsp;
  owner_type owner;
  exp_type exps[$];
  exp_type e;
  logic [7:0] sent[$];
  logic [31:0] seed = 32'h0000083E;
  int errors, tests_run, n_rsp, irqs, cyc;
  shared_memory_mailbox_link shared_memory_mailbox_link_i (
    .ref_clk_i(clk), .sys_rst_i(rst), .pc_sel_i(sel), .pc_wr_i(wr),
    .pc_addr_i(addr), .pc_wdata_i(wdata), .pc_rdata_o(rdata),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(ready),
    .rsp_valid_o(rvalid), .rsp_o(rsp), .attention_flag_o(attn),
    .irq_pc_o(irq), .disk_addr_o(daddr), .disk_pages_o(dpages),
    .printer_req_i(preq), .printer_owner_o(owner));
  pc_side_model pc_side_model_i (
    .clk_i(clk), .rdata_i(rdata), .sel_o(sel), .wr_o(wr),
    .addr_o(addr), .wdata_o(wdata));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input string n, input logic [23:0] x,
                       input logic [23:0] g);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmd_go(input op_type op, input logic [7:0] a,
                        input logic [15:0] d, input logic [1:0] at,
                        input logic chk, input logic [15:0] xd,
                        input logic xok);
    int k;
    k = n_rsp;
    @(posedge clk);
    exps.push_back(exp_type'{chk, '{xd, xok}});
    cmd_valid <= 1'b1;
    cmd <= '{op, a, d, at[1], at[0]};
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 10 && n_rsp == k; i++) @(posedge clk);
    check("rsp_seen", 1'b1, n_rsp != k);
  endtask
  task automatic mk(input logic [7:0] b, input logic [15:0] c);
    pc_side_model_i.wr(b, c);
    pc_side_model_i.wr(b + 8'h01, 16'h0000);
    pc_side_model_i.wr(b + 8'h02, 16'h0000);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end
  always @(negedge clk) begin
    if (irq === 1'b1) irqs++;
    if (rvalid === 1'b1) begin
      e = exps.pop_front();
      check("rsp_ok", e.r.ok, rsp.ok);
      check("busy_ready", 1'b0, ready);
      if (e.chk) check("rsp_data", e.r.data, rsp.data);
      n_rsp++;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] q, w;
    logic [7:0] b, h;
    int i0, t0;
    static logic [1:0] pst[6] = '{2'b10, 2'b11, 2'b00, 2'b10, 2'b10, 2'b00};
    static owner_type pow[6] = '{OWN_HOST, OWN_HOST, OWN_PC, OWN_PC, OWN_HOST,
                                 OWN_NONE};
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    preq = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      pc_side_model_i.acc(1'b0, 16'h8030 + 16'(2 * k), 16'h0000, q);
      check("reg_reset", 16'h0000, q);
    end
    check("owner_reset", OWN_NONE, owner);
    pc_side_model_i.acc(1'b1, 16'h9000, 16'h5A5A, q);
    pc_side_model_i.acc(1'b0, 16'h9000, 16'h0000, q);
    check("unmapped", 16'h0000, q);
    mk(8'h40, 16'h0003);
    mk(8'h60, 16'h0003);
    mk(8'h20, 16'h0002);
    pc_side_model_i.acc(1'b1, OFS_HOST_TO_PC_Q, 16'h0040, q);
    pc_side_model_i.acc(1'b1, OFS_PC_TO_HOST_Q, 16'h0060, q);
    pc_side_model_i.acc(1'b0, OFS_HOST_TO_PC_Q, 16'h0000, q);
    check("queue_ptr", 16'h0040, q);
    // Second round makes the put pointer wrap
    for (int r = 0; r < 2; r++) begin
      i0 = irqs;
      for (int k = 0; k < 4; k++) begin
        b = rnd();
        if (k < 3) sent.push_back(b);
        cmd_go(OP_SEND, 8'h00, {8'h00, b}, 2'b00, k < 3, 16'(k), k < 3);
      end
      check("attention_set", 1'b1, attn);
      check("irq_untimed", 3, irqs - i0);
      pc_side_model_i.service();
      check("attention_clr", 1'b0, attn);
      while (sent.size() > 0)
        check("box_addr", sent.pop_front(),
              pc_side_model_i.boxes.pop_front());
    end
    i0 = irqs;
    b = rnd();
    h = rnd();
    sent.push_back(b);
    sent.push_back(h);
    cmd_go(OP_SEND, 8'h00, {8'h00, b}, 2'b11, 1'b1, 16'h0000, 1'b1);
    t0 = cyc;
    cmd_go(OP_SEND, 8'h00, {8'h00, h}, 2'b11, 1'b1, 16'h0001, 1'b1);
    while (irqs == i0 && cyc - t0 < IRQ_DELAY_CYC + 50) @(posedge clk);
    check("timer_delay", 1'b1, cyc - t0 >= IRQ_DELAY_CYC - 3 &&
          cyc - t0 <= IRQ_DELAY_CYC + 4);
    repeat (60) @(posedge clk);
    check("timer_once", 1, irqs - i0);
    pc_side_model_i.service();
    while (sent.size() > 0)
      check("timed_box", sent.pop_front(), pc_side_model_i.boxes.pop_front());
    for (int k = 0; k < 3; k++) begin
      b = rnd();
      sent.push_back(b);
      cmd_go(OP_PUT_BYTE, 8'h20, {8'h00, b}, 2'b10, k < 2, 16'(k), k < 2);
    end
    for (int k = 0; k < 2; k++) begin
      pc_side_model_i.rd(8'h23 + 8'(k), q);
      check("fifo_word", sent.pop_front(), q[7:0]);
    end
    pc_side_model_i.rd(8'h22, q);
    check("put_ptr", 16'h0002, q);
    pc_side_model_i.rd(8'h21, q);
    check("get_kept", 16'h0000, q);
    b = rnd();
    h = rnd();
    pc_side_model_i.put(b);
    pc_side_model_i.put(h);
    cmd_go(OP_GET, 8'h00, 16'h0000, 2'b10, 1'b1, {8'h00, b}, 1'b1);
    cmd_go(OP_GET, 8'h00, 16'h0000, 2'b10, 1'b1, {8'h00, h}, 1'b1);
    cmd_go(OP_GET, 8'h00, 16'h0000, 2'b10, 1'b0, 16'h0000, 1'b0);
    pc_side_model_i.rd(8'h61, q);
    check("get_ptr", 16'h0002, q);
    for (int k = 0; k < CONSOLE_WORDS; k++) begin
      w = {rnd(), rnd()};
      cmd_go(OP_MEM_WR, CONSOLE_IDX + 8'(k), w, 2'b00, 1'b0, 16'h0, 1'b1);
      pc_side_model_i.rd(CONSOLE_IDX + 8'(k), q);
      check("console_wr", w, q);
    end
    w = {rnd(), rnd()};
    pc_side_model_i.wr(CONSOLE_IDX + 8'h03, w);
    cmd_go(OP_MEM_RD, CONSOLE_IDX + 8'h03, 16'h0, 2'b00, 1'b1, w, 1'b1);
    for (int k = 0; k < 3; k++) begin
      b = rnd();
      w = {rnd(), rnd()};
      pc_side_model_i.wr(8'h70, {8'h00, b});
      pc_side_model_i.wr(8'h71, w);
      pc_side_model_i.wr(8'h72, 16'(1023 + k));
      cmd_go(OP_DISK, 8'h70, 16'h0000, 2'b00, 1'b0, 16'h0000, 1'b1);
      check("disk_addr", {b, w}, daddr);
      check("disk_pages", (2046 + k) / 1024, dpages);
    end
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      preq <= pst[k][1];
      if (k == 1 || k == 4)
        pc_side_model_i.acc(1'b1, OFS_PRINTER, {15'h0000, pst[k][0]}, q);
      repeat (3) @(posedge clk);
      #1 check("printer_owner", pow[k], owner);
    end
    summarize();
  end
endmodule
